// >>> hw/pms_pkg.sv
// Shared constants and types for the converter programming sequencer
package pms_pkg;
	localparam int NPOL = 4;
	localparam int NAUX = 4;
	localparam int NGRP = 2;
	localparam int NREG = 8;
	localparam int NVM_LEN = NPOL * NREG;
	localparam int CLK_NS = 100;
	localparam real T_INIT_MS = 11.5;
	localparam real T_POL_MS = 26.5;
	localparam real T_AD_MS = 7.5;
	localparam int INIT_CYC = int'($ceil(T_INIT_MS * 1.0e6 / CLK_NS));
	localparam int POL_CYC = int'($ceil(T_POL_MS * 1.0e6 / CLK_NS));
	localparam int AD_CYC = int'($ceil(T_AD_MS * 1.0e6 / CLK_NS));
	localparam int TMR_W = 20;
	// Serial line: 1 us bits, header start+rw+addr5+reg4+data8+parity
	localparam int BIT_CYC = 10;
	localparam int HDR_BITS = 20;
	localparam int RSP_BITS = 10;
	localparam logic [7:0] CRC_POLY = 8'h07;
	localparam logic [7:0] CRC_INIT = 8'hFF;
	localparam logic [3:0] REG_MON = 4'h8;
	localparam logic [NPOL-1:0] POL_GRP = 4'hC;
	localparam int SY_SUP = 7;
	localparam int SY_BUS = 6;
	localparam int SY_LCK = 5;
	localparam int SY_AUX = 1;
	localparam int SY_LINE = 0;
	localparam logic [7:0] SY_RST = 8'h01;
	typedef struct packed {
		logic wr;
		logic [4:0] addr;
		logic [3:0] rsel;
		logic [7:0] data;
	} pms_op_t;
	typedef struct packed {
		logic [NGRP-1:0] auto_on;
		logic [NGRP-1:0] stat_en;
		logic [NGRP-1:0] par_en;
		logic sw_wp;
	} pms_cfg_t;
	typedef struct packed {
		logic [7:0] status;
		logic [7:0] vout;
		logic [7:0] iout;
		logic [7:0] temp;
	} pms_mon_t;
endpackage

// >>> hw/pms_sync3.sv
// Three-stage input synchroniser with second/third stage agreement
`timescale 1ns/1ps
module pms_sync3 #(
	parameter int W = 1,
	parameter logic [W-1:0] RST = '0
) (
	input wire logic i_clk,
	input wire logic i_arst_n,
	input wire logic [W-1:0] i_async,
	output logic [W-1:0] o_sync
);
	logic [W-1:0] s1_q, s2_q, s3_q, out_q;
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			s1_q <= RST;
			s2_q <= RST;
			s3_q <= RST;
			out_q <= RST;
		end else begin
			s1_q <= i_async;
			s2_q <= s1_q;
			s3_q <= s2_q;
			// Holds its value while the two late stages disagree
			out_q <= (s2_q & s3_q) | (out_q & (s2_q | s3_q));
		end
	end
	assign o_sync = out_q;
endmodule

// >>> hw/pms_link.sv
// Open-drain converter line engine: one framed transfer with parity, ack and reply
`timescale 1ns/1ps
module pms_link (
	input wire logic i_clk,
	input wire logic i_arst_n,
	input wire logic i_start,
	input pms_pkg::pms_op_t i_op,
	input wire logic i_line,
	output logic o_line_o,
	output logic o_line_oe,
	output logic o_busy,
	output logic o_done,
	output logic o_ok,
	output logic [7:0] o_rdata
);
	typedef enum logic [1:0] {L_IDLE, L_SEND, L_RESP} pms_lst_t;
	pms_lst_t st_q;
	logic [pms_pkg::HDR_BITS-1:0] sh_q;
	logic [pms_pkg::RSP_BITS-1:0] rx_q;
	logic [3:0] cyc_q;
	logic [4:0] bit_q;
	logic wr_q, done_q, ok_q;
	logic [7:0] rdat_q;
	wire bit_end = (cyc_q == 4'(pms_pkg::BIT_CYC - 1));
	wire mid = (cyc_q == 4'(pms_pkg::BIT_CYC / 2));
	wire [4:0] hdr_last = 5'(pms_pkg::HDR_BITS - 1);
	wire [4:0] rsp_last = wr_q ? 5'h0 : 5'(pms_pkg::RSP_BITS - 1);
	wire par = ^{i_op.wr, i_op.addr, i_op.rsel, i_op.data};
	// Writes answer with the ack bit only; reads add data and even parity
	wire ack = wr_q ? !rx_q[0] : !rx_q[9];
	wire par_ok = !(^rx_q[8:0]);
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			st_q <= L_IDLE;
			sh_q <= '1;
			rx_q <= '1;
			cyc_q <= 4'h0;
			bit_q <= 5'h0;
			wr_q <= 1'b0;
			done_q <= 1'b0;
			ok_q <= 1'b0;
			rdat_q <= 8'h00;
		end else begin
			done_q <= 1'b0;
			cyc_q <= (st_q == L_IDLE || bit_end) ? 4'h0 : cyc_q + 4'h1;
			unique case (st_q)
				L_IDLE: if (i_start) begin
					st_q <= L_SEND;
					sh_q <= {1'b0, i_op.wr, i_op.addr, i_op.rsel, i_op.data, par};
					wr_q <= i_op.wr;
					bit_q <= 5'h0;
					rx_q <= '1;
				end
				L_SEND: if (bit_end) begin
					sh_q <= {sh_q[pms_pkg::HDR_BITS-2:0], 1'b1};
					bit_q <= (bit_q == hdr_last) ? 5'h0 : bit_q + 5'h1;
					if (bit_q == hdr_last)
						st_q <= L_RESP;
				end
				L_RESP: begin
					if (mid)
						rx_q <= {rx_q[pms_pkg::RSP_BITS-2:0], i_line};
					if (bit_end) begin
						bit_q <= bit_q + 5'h1;
						if (bit_q == rsp_last) begin
							st_q <= L_IDLE;
							done_q <= 1'b1;
							ok_q <= ack && (wr_q || par_ok);
							rdat_q <= rx_q[8:1];
						end
					end
				end
			endcase
		end
	end
	assign o_line_o = 1'b0;
	assign o_line_oe = (st_q == L_SEND) && !sh_q[pms_pkg::HDR_BITS-1];
	assign o_busy = (st_q != L_IDLE);
	assign o_done = done_q;
	assign o_ok = ok_q;
	assign o_rdata = rdat_q;
endmodule

// >>> hw/pms_seq.sv
// Converter setup loader, programmer, turn-on, host pass-through and monitor
`timescale 1ns/1ps
// Summary of operation
// - After supply good, load setup, run CRC
// - Program converters only after bus voltage good
// - Transfers carry parity, ack and readback
// - Ack and readback good sets status bit
// - Auto turn-on per group, else host command
// - Initialization interval lasts 11.5 ms
// - Each converter slot lasts 26.5 ms
// - Each present auxiliary adds 7.5 ms
// - Programming interval ends at turn-on
// - Host reaches converter registers via serial line
// - Lock pin or software lock blocks host writes
// - Monitoring copies converter data while enabled
// - Separate per-group status and parametric enables
// - Report protection status and live measurements
// - Report per-converter programming status and CRC
// - Sample four auxiliary good inputs, high good
// - Re-register sampled auxiliary status every cycle for reading
// - Bus undervoltage clears status, saves counter
module pms_seq #(
	parameter int INIT_CYC = pms_pkg::INIT_CYC,
	parameter int POL_CYC = pms_pkg::POL_CYC,
	parameter int AD_CYC = pms_pkg::AD_CYC
) (
	input wire logic i_clk,
	input wire logic i_arst_n,
	input wire logic i_supply_ok,
	input wire logic i_bus_ok,
	input wire logic i_write_lock_n,
	input wire logic [pms_pkg::NAUX-1:0] i_aux_good,
	input wire logic [pms_pkg::NAUX-1:0] i_aux_present,
	input pms_pkg::pms_cfg_t i_cfg,
	input wire logic [pms_pkg::NGRP-1:0] i_host_on,
	input wire logic i_host_valid,
	input pms_pkg::pms_op_t i_host_req,
	output logic o_host_ready,
	output logic o_host_done,
	output logic o_host_err,
	output logic [7:0] o_host_rdata,
	output logic o_nvm_rd,
	output logic [5:0] o_nvm_addr,
	input wire logic [7:0] i_nvm_data,
	input wire logic i_nvm_valid,
	output logic o_nvm_save,
	input wire logic i_line_i,
	output logic o_line_o,
	output logic o_line_oe,
	output logic [pms_pkg::NPOL-1:0] o_prog_status,
	output logic o_crc_done,
	output logic o_crc_err,
	output logic o_prog_done,
	output logic [pms_pkg::NGRP-1:0] o_group_on,
	output logic [pms_pkg::NAUX-1:0] o_aux_good,
	output pms_pkg::pms_mon_t o_mon [pms_pkg::NPOL]
);
	typedef enum logic [3:0] {
		S_OFF, S_LOAD, S_INIT, S_BUSW, S_WR, S_RB, S_PAD, S_AUX, S_ON, S_RUN, S_HALT
	} pms_st_t;
	typedef enum logic [1:0] {O_NONE, O_SEQ, O_MON, O_HOST} pms_own_t;
	function automatic logic [7:0] pms_crc(input logic [7:0] c, input logic [7:0] d);
		logic [7:0] r;
		r = c ^ d;
		for (int k = 0; k < 8; k++) begin
			r = r[7] ? ({r[6:0], 1'b0} ^ pms_pkg::CRC_POLY) : {r[6:0], 1'b0};
		end
		return r;
	endfunction
	pms_st_t st_q, st_d;
	pms_own_t own_q;
	logic [7:0] ram [pms_pkg::NVM_LEN];
	logic [5:0] idx_q;
	logic [7:0] crc_q;
	logic crc_done_q, crc_err_q;
	logic [pms_pkg::TMR_W-1:0] tinit_q, slot_q;
	logic [1:0] pol_q, aux_q, mpol_q, msel_q;
	logic [2:0] reg_q;
	logic [3:0] mtag_q;
	logic [pms_pkg::NPOL-1:0] prog_q;
	logic [pms_pkg::NGRP-1:0] on_q;
	logic iss_q, save_q, hdone_q, herr_q;
	logic [7:0] hrd_q;
	logic [pms_pkg::NAUX-1:0] auxg_q;
	pms_pkg::pms_mon_t mon_q [pms_pkg::NPOL];
	// Synchronised pins
	logic [7:0] sy;
	pms_sync3 #(
		.W(8),
		.RST(pms_pkg::SY_RST)
	) u_sync (
		.i_clk(i_clk),
		.i_arst_n(i_arst_n),
		.i_async({i_supply_ok, i_bus_ok, i_write_lock_n, i_aux_good, i_line_i}),
		.o_sync(sy)
	);
	wire sup_ok = sy[pms_pkg::SY_SUP];
	wire bus_ok = sy[pms_pkg::SY_BUS];
	wire wlock_n = sy[pms_pkg::SY_LCK];
	wire [3:0] aux_s = sy[pms_pkg::SY_AUX+3:pms_pkg::SY_AUX];
	wire line_s = sy[pms_pkg::SY_LINE];

	// Serial engine
	logic lk_done, lk_ok;
	logic [7:0] lk_rdata;
	pms_pkg::pms_op_t seq_op, mon_op, lk_op;
	wire lk_start;
	pms_link u_link (
		.i_clk(i_clk),
		.i_arst_n(i_arst_n),
		.i_start(lk_start),
		.i_op(lk_op),
		.i_line(line_s),
		.o_line_o(o_line_o),
		.o_line_oe(o_line_oe),
		.o_busy(),
		.o_done(lk_done),
		.o_ok(lk_ok),
		.o_rdata(lk_rdata)
	);

	// Decode
	wire powered = (st_q inside {S_WR, S_RB, S_PAD, S_AUX, S_ON, S_RUN});
	wire uv_drop = sup_ok && !bus_ok && powered;
	wire [4:0] ram_a = {pol_q, reg_q};
	wire [7:0] ram_dat = ram[ram_a];
	wire load_last = i_nvm_valid && (idx_q == 6'(pms_pkg::NVM_LEN));
	wire crc_match = (crc_q == i_nvm_data);
	wire init_done = (tinit_q >= pms_pkg::TMR_W'(INIT_CYC - 1));
	wire pol_end = (slot_q >= pms_pkg::TMR_W'(POL_CYC - 1));
	wire ad_end = (slot_q >= pms_pkg::TMR_W'(AD_CYC - 1));
	wire last_pol = (pol_q == 2'(pms_pkg::NPOL - 1));
	wire last_aux = (aux_q == 2'(pms_pkg::NAUX - 1));
	wire last_reg = (reg_q == 3'(pms_pkg::NREG - 1));
	wire seq_done = lk_done && (own_q == O_SEQ);
	wire rb_good = lk_ok && (lk_rdata == ram_dat);
	wire pad_adv = (st_q == S_PAD) && pol_end;
	wire aux_adv = (st_q == S_AUX) && (!i_aux_present[aux_q] || ad_end);
	wire prog_set = (st_q == S_RB) && seq_done && rb_good && last_reg;

	// Arbitration of the serial engine
	wire seq_go = (st_q == S_WR || st_q == S_RB) && !iss_q;
	wire in_run = (st_q == S_RUN) && !iss_q;
	wire wr_blk = i_host_req.wr && (!wlock_n || i_cfg.sw_wp);
	wire host_take = in_run && i_host_valid;
	wire host_go = host_take && !wr_blk;
	wire mgrp = pms_pkg::POL_GRP[mpol_q];
	// Status slot uses status enable, the other three the parametric enable
	wire mon_en = (msel_q == 2'h0) ? i_cfg.stat_en[mgrp] : i_cfg.par_en[mgrp];
	wire mon_adv = in_run && !i_host_valid;
	wire mon_go = mon_adv && mon_en;
	assign lk_start = seq_go || host_go || mon_go;
	assign seq_op = '{wr: (st_q == S_WR), addr: 5'(pol_q), rsel: {1'b0, reg_q}, data: ram_dat};
	assign mon_op = '{wr: 1'b0, addr: 5'(mpol_q), rsel: pms_pkg::REG_MON | {2'h0, msel_q},
		data: 8'h00};
	assign lk_op = host_go ? i_host_req : (mon_go ? mon_op : seq_op);

	// Sequencer next state
	always_comb begin
		st_d = st_q;
		unique case (st_q)
			S_OFF: if (sup_ok) st_d = S_LOAD;
			S_LOAD: if (load_last) st_d = crc_match ? S_INIT : S_HALT;
			S_INIT: if (init_done) st_d = S_BUSW;
			S_BUSW: if (bus_ok) st_d = S_WR;
			S_WR: if (seq_done) st_d = lk_ok ? S_RB : S_PAD;
			S_RB: if (seq_done) st_d = (rb_good && !last_reg) ? S_WR : S_PAD;
			S_PAD: if (pol_end) st_d = last_pol ? S_AUX : S_WR;
			S_AUX: if (aux_adv && last_aux) st_d = S_ON;
			S_ON: st_d = S_RUN;
			S_RUN, S_HALT: st_d = st_q;
			default: st_d = S_OFF;
		endcase
		if (uv_drop)
			st_d = S_BUSW;
		if (!sup_ok)
			st_d = S_OFF;
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n)
			st_q <= S_OFF;
		else
			st_q <= st_d;
	end
	// Setup copy: no reset needed, always rewritten before use
	always_ff @(posedge i_clk) begin
		if (st_q == S_LOAD && i_nvm_valid && !load_last)
			ram[idx_q[4:0]] <= i_nvm_data;
	end

	// Load pointer, CRC and its result flags
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			idx_q <= 6'h00;
			crc_q <= pms_pkg::CRC_INIT;
			crc_done_q <= 1'b0;
			crc_err_q <= 1'b0;
		end else if (st_q == S_OFF) begin
			idx_q <= 6'h00;
			crc_q <= pms_pkg::CRC_INIT;
			crc_done_q <= 1'b0;
			crc_err_q <= 1'b0;
		end else if (st_q == S_LOAD && i_nvm_valid) begin
			idx_q <= idx_q + 6'h01;
			crc_q <= pms_crc(crc_q, i_nvm_data);
			if (load_last) begin
				crc_done_q <= 1'b1;
				crc_err_q <= !crc_match;
			end
		end
	end

	// Interval timers
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			tinit_q <= '0;
			slot_q <= '0;
		end else begin
			// Started at supply good, so loading time counts toward it
			if (st_q == S_OFF)
				tinit_q <= '0;
			else if (!init_done)
				tinit_q <= tinit_q + 1'b1;
			if (st_q == S_BUSW || pad_adv || aux_adv)
				slot_q <= '0;
			else if (!pol_end)
				slot_q <= slot_q + 1'b1;
		end
	end

	// Converter, register and auxiliary slot pointers
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			pol_q <= 2'h0;
			reg_q <= 3'h0;
			aux_q <= 2'h0;
		end else if (st_q == S_BUSW) begin
			pol_q <= 2'h0;
			reg_q <= 3'h0;
			aux_q <= 2'h0;
		end else begin
			if (pad_adv && !last_pol)
				pol_q <= pol_q + 2'h1;
			if (st_q == S_RB && seq_done && rb_good && !last_reg)
				reg_q <= reg_q + 3'h1;
			else if (pad_adv)
				reg_q <= 3'h0;
			if (aux_adv && !last_aux)
				aux_q <= aux_q + 2'h1;
		end
	end

	// Programming status and turn-on
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			prog_q <= '0;
			on_q <= '0;
			save_q <= 1'b0;
		end else begin
			save_q <= uv_drop && !save_q;
			if (st_q == S_OFF || uv_drop)
				prog_q <= '0;
			else if (prog_set)
				prog_q[pol_q] <= 1'b1;
			if (st_q == S_OFF || uv_drop)
				on_q <= '0;
			else if (st_q == S_ON)
				on_q <= on_q | i_cfg.auto_on | i_host_on;
			else if (st_q == S_RUN)
				on_q <= on_q | i_host_on;
		end
	end

	// Transfer ownership
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			iss_q <= 1'b0;
			own_q <= O_NONE;
		end else begin
			if (lk_start)
				iss_q <= 1'b1;
			else if (lk_done)
				iss_q <= 1'b0;
			// An abandoned transfer finishes on the line but its answer is dropped
			if (lk_start)
				own_q <= host_go ? O_HOST : (mon_go ? O_MON : O_SEQ);
			else if (lk_done || uv_drop || !sup_ok)
				own_q <= O_NONE;
		end
	end

	// Host pass-through answers
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			hdone_q <= 1'b0;
			herr_q <= 1'b0;
			hrd_q <= 8'h00;
		end else begin
			hdone_q <= 1'b0;
			if (host_take && wr_blk) begin
				hdone_q <= 1'b1;
				herr_q <= 1'b1;
			end else if (own_q == O_HOST && (uv_drop || !sup_ok)) begin
				hdone_q <= 1'b1;
				herr_q <= 1'b1;
			end else if (lk_done && own_q == O_HOST) begin
				hdone_q <= 1'b1;
				herr_q <= !lk_ok;
				hrd_q <= lk_rdata;
			end
		end
	end

	// Monitoring walk and capture
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			mpol_q <= 2'h0;
			msel_q <= 2'h0;
			mtag_q <= 4'h0;
			for (int p = 0; p < pms_pkg::NPOL; p++)
				mon_q[p] <= '0;
		end else begin
			if (mon_adv) begin
				msel_q <= msel_q + 2'h1;
				if (msel_q == 2'h3)
					mpol_q <= mpol_q + 2'h1;
			end
			if (mon_go)
				mtag_q <= {mpol_q, msel_q};
			if (lk_done && own_q == O_MON && lk_ok) begin
				unique case (mtag_q[1:0])
					2'h0: mon_q[mtag_q[3:2]].status <= lk_rdata;
					2'h1: mon_q[mtag_q[3:2]].vout <= lk_rdata;
					2'h2: mon_q[mtag_q[3:2]].iout <= lk_rdata;
					2'h3: mon_q[mtag_q[3:2]].temp <= lk_rdata;
				endcase
			end
		end
	end

	// Auxiliary good capture, high means normal operation
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n)
			auxg_q <= '0;
		else
			auxg_q <= aux_s;
	end

	assign o_host_ready = in_run;
	assign o_host_done = hdone_q;
	assign o_host_err = herr_q;
	assign o_host_rdata = hrd_q;
	assign o_nvm_rd = (st_q == S_LOAD);
	assign o_nvm_addr = idx_q;
	assign o_nvm_save = save_q;
	assign o_prog_status = prog_q;
	assign o_crc_done = crc_done_q;
	assign o_crc_err = crc_err_q;
	assign o_prog_done = (st_q == S_RUN);
	assign o_group_on = on_q;
	assign o_aux_good = auxg_q;
	assign o_mon = mon_q;
endmodule

// >>> tb/pms_seq_sva.sv
// Port-level assertions for the converter programming sequencer
`timescale 1ns/1ps
module pms_seq_sva #(
	parameter int INIT_CYC = 400,
	parameter int POL_CYC = 600,
	parameter int AD_CYC = 50
) (
	input wire logic i_clk,
	input wire logic i_arst_n,
	input wire logic [pms_pkg::NAUX-1:0] i_aux_present,
	input pms_pkg::pms_cfg_t i_cfg,
	input wire logic [pms_pkg::NGRP-1:0] i_host_on,
	input wire logic i_host_valid,
	input pms_pkg::pms_op_t i_host_req,
	input wire logic o_host_ready,
	input wire logic o_host_done,
	input wire logic o_host_err,
	input wire logic o_nvm_rd,
	input wire logic o_nvm_save,
	input wire logic o_line_oe,
	input wire logic [pms_pkg::NPOL-1:0] o_prog_status,
	input wire logic o_crc_done,
	input wire logic o_crc_err,
	input wire logic o_prog_done,
	input wire logic [pms_pkg::NGRP-1:0] o_group_on
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_arst_n);
	// Cycles since the load phase was entered
	logic [19:0] cnt_q;
	logic rd_q;
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			cnt_q <= 20'h00000;
			rd_q <= 1'b0;
		end else begin
			rd_q <= o_nvm_rd;
			cnt_q <= (o_nvm_rd && !rd_q) ? 20'h00000 : cnt_q + 20'h00001;
		end
	end
	property p_crc_load;
		$rose(o_crc_done) |-> $fell(o_nvm_rd);
	endproperty
	a_crc_load: assert property (p_crc_load) else $error("crc result without end of load");
	property p_halt_quiet;
		o_crc_err |-> !o_line_oe;
	endproperty
	a_halt_quiet: assert property (p_halt_quiet) else $error("line driven after crc error");
	property p_init;
		$rose(o_line_oe) && !o_prog_done |-> cnt_q >= INIT_CYC - 2;
	endproperty
	a_init: assert property (p_init) else $error("programming before init interval");
	property p_total;
		$rose(o_prog_done) |->
			cnt_q >= INIT_CYC + 4 * POL_CYC + $countones(i_aux_present) * AD_CYC - 2;
	endproperty
	a_total: assert property (p_total) else $error("programming interval too short");
	property p_done_crc;
		$rose(o_prog_done) |-> o_crc_done && !o_crc_err;
	endproperty
	a_done_crc: assert property (p_done_crc) else $error("turn-on without good crc");
	property p_auto_on;
		$rose(o_prog_done) |-> o_group_on == ($past(i_cfg.auto_on) | $past(i_host_on));
	endproperty
	a_auto_on: assert property (p_auto_on) else $error("auto turn-on groups wrong");
	property p_host_on;
		o_prog_done && i_host_on != 2'h0 |=> (o_group_on & $past(i_host_on)) == $past(i_host_on);
	endproperty
	a_host_on: assert property (p_host_on) else $error("host turn-on ignored");
	property p_wp;
		i_host_valid && o_host_ready && i_host_req.wr && i_cfg.sw_wp
			|=> o_host_done && o_host_err && !o_line_oe;
	endproperty
	a_wp: assert property (p_wp) else $error("protected write not refused");
	property p_bus_drop;
		o_nvm_save |-> o_prog_status == 4'h0 && o_group_on == 2'h0 ##1 !o_nvm_save;
	endproperty
	a_bus_drop: assert property (p_bus_drop) else $error("bus drop did not clear status");
	property p_hold_status;
		($past(o_prog_status) & ~o_prog_status) != 4'h0 |-> o_nvm_save || !o_crc_done;
	endproperty
	a_hold_status: assert property (p_hold_status) else $error("status bit lost");
	c_prog: cover property ($rose(o_prog_done));
	c_save: cover property (o_nvm_save);
	c_refused: cover property (o_host_done && o_host_err);
	c_crc_err: cover property ($rose(o_crc_err));
endmodule

bind pms_seq pms_seq_sva #(.INIT_CYC(INIT_CYC), .POL_CYC(POL_CYC), .AD_CYC(AD_CYC)) u_sva (
	.i_clk, .i_arst_n, .i_aux_present, .i_cfg, .i_host_on, .i_host_valid, .i_host_req,
	.o_host_ready, .o_host_done, .o_host_err, .o_nvm_rd, .o_nvm_save, .o_line_oe,
	.o_prog_status, .o_crc_done, .o_crc_err, .o_prog_done, .o_group_on);

// >>> tb/pms_conv_model.sv
// Behavioural bank of converters on the shared open-drain line
`timescale 1ns/1ps
module pms_conv_model (
	input wire logic i_clk,
	input wire logic i_line,
	input wire logic [3:0] i_nak,
	output logic o_pull
);
	logic [7:0] mem [32][16];
	logic [19:0] h;
	logic [9:0] r;
	logic ok;
	initial begin
		for (int a = 0; a < 32; a++)
			for (int s = 0; s < 16; s++)
				mem[a][s] = {a[3:0], s[3:0]};
		o_pull = 1'b0;
		forever begin
			@(posedge i_clk);
			if (i_line === 1'b0) begin
				for (int k = 19; k >= 0; k--) begin
					repeat (k == 19 ? 5 : 10) @(posedge i_clk);
					h[k] = i_line;
				end
				// Bad parity or a commanded refusal gets no ack
				ok = !(^h[18:0]) && h[17:15] == 3'h0 && !i_nak[h[14:13]];
				if (h[18] && ok)
					mem[h[17:13]][h[12:9]] = h[8:1];
				r = {1'b0, mem[h[17:13]][h[12:9]], ^mem[h[17:13]][h[12:9]]};
				repeat (5) @(posedge i_clk);
				// A write answers with the ack bit only
				for (int j = 9; j >= (h[18] ? 9 : 0); j--) begin
					#1 o_pull = ok && !r[j];
					repeat (10) @(posedge i_clk);
				end
				#1 o_pull = 1'b0;
			end
		end
	end
	// Measurements refresh every 1 ms, held constant so reads stay predictable
	always begin
		repeat (10000) @(posedge i_clk);
		for (int a = 0; a < 4; a++)
			for (int s = 8; s < 12; s++)
				mem[a][s] = {a[3:0], s[3:0]};
	end
endmodule

// >>> tb/pms_seq_tb_top.sv
// Self-checking bench for the converter programming sequencer
`timescale 1ns/1ps
module pms_seq_tb_top;
	localparam int INIT = 400;
	logic i_clk = 1'b0, i_arst_n = 1'b0, i_supply_ok = 1'b0, i_bus_ok = 1'b0;
	logic i_write_lock_n = 1'b1, i_host_valid = 1'b0, i_nvm_valid = 1'b0;
	logic [3:0] i_aux_good = 4'hA, i_aux_present = 4'h5, nak = 4'h4;
	logic [1:0] i_host_on = 2'h0;
	logic [7:0] i_nvm_data = 8'h00;
	pms_pkg::pms_cfg_t i_cfg = '{auto_on: 2'h1, stat_en: 2'h3, par_en: 2'h1, sw_wp: 1'b0};
	pms_pkg::pms_op_t i_host_req = '0;
	logic o_host_ready, o_host_done, o_host_err, o_nvm_rd, o_nvm_save, o_line_o, o_line_oe;
	logic o_crc_done, o_crc_err, o_prog_done, pull;
	logic [7:0] o_host_rdata;
	logic [5:0] o_nvm_addr;
	logic [3:0] o_prog_status, o_aux_good;
	logic [1:0] o_group_on;
	pms_pkg::pms_mon_t o_mon [pms_pkg::NPOL];
	logic [7:0] nvm [33];
	// Converter 2 refuses; group 1 has parametric retrieval off
	logic [31:0] mon_exp [4] = '{32'h08090A0B, 32'h18191A1B, 32'h00000000, 32'h38000000};
	wire i_line_i = (o_line_oe ? o_line_o : 1'b1) & !pull;
	wire [2:0] flags = {o_host_done, o_prog_done, o_crc_done};
	int failures = 0, num_checks = 0, cyc = 0, oe_rises = 0, saves = 0;

	pms_seq #(.INIT_CYC(INIT), .POL_CYC(600), .AD_CYC(50)) u_dut (
		.i_clk, .i_arst_n, .i_supply_ok, .i_bus_ok, .i_write_lock_n, .i_aux_good,
		.i_aux_present, .i_cfg, .i_host_on, .i_host_valid, .i_host_req, .o_host_ready,
		.o_host_done, .o_host_err, .o_host_rdata, .o_nvm_rd, .o_nvm_addr, .i_nvm_data,
		.i_nvm_valid, .o_nvm_save, .i_line_i, .o_line_o, .o_line_oe, .o_prog_status,
		.o_crc_done, .o_crc_err, .o_prog_done, .o_group_on, .o_aux_good, .o_mon);
	pms_conv_model u_conv (.i_clk(i_clk), .i_line(i_line_i), .i_nak(nak), .o_pull(pull));

	always #50 i_clk = ~i_clk;
	always @(posedge o_line_oe) oe_rises++;
	always @(posedge o_nvm_save) saves++;
	always @(negedge i_clk) begin
		i_nvm_valid <= o_nvm_rd;
		i_nvm_data <= nvm[o_nvm_addr];
	end
	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 90000) begin
			failures++;
			conclude();
		end
	end

	task automatic conclude();
		$display("Checks %0d, mismatches %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cyc_n(input int n);
		repeat (n) @(negedge i_clk);
	endtask
	task automatic wait_hi(input int w, input int lim);
		for (int k = 0; k < lim && flags[w] !== 1'b1; k++)
			@(negedge i_clk);
		chk(flags[w], 1);
	endtask
	task automatic host(input logic wr, input logic [1:0] a, input logic [3:0] rs,
		input logic [7:0] d, input logic [7:0] ed, input logic ee);
		@(negedge i_clk);
		i_host_req = '{wr: wr, addr: {3'h0, a}, rsel: rs, data: d};
		i_host_valid = 1'b1;
		for (int k = 0; k < 2000 && o_host_ready !== 1'b1; k++)
			@(negedge i_clk);
		@(negedge i_clk);
		i_host_valid = 1'b0;
		wait_hi(2, 400);
		chk(o_host_err, ee);
		if (!wr && !ee)
			chk(o_host_rdata, ed);
	endtask
	function automatic logic [7:0] crc8();
		logic [7:0] c;
		c = 8'hFF;
		for (int k = 0; k < 32; k++) begin
			c ^= nvm[k];
			for (int b = 0; b < 8; b++)
				c = c[7] ? (c << 1) ^ 8'h07 : c << 1;
		end
		return c;
	endfunction

	initial begin
		for (int k = 0; k < 32; k++)
			nvm[k] = 8'h10 + 8'(k);
		nvm[32] = ~crc8();
		cyc_n(4);
		i_arst_n = 1'b1;
		i_supply_ok = 1'b1;
		i_bus_ok = 1'b1;
		wait_hi(0, 300);
		chk(o_crc_err, 1);
		cyc_n(2000);
		chk(oe_rises, 0);
		i_supply_ok = 1'b0;
		i_bus_ok = 1'b0;
		cyc_n(20);
		nvm[32] = crc8();
		i_supply_ok = 1'b1;
		wait_hi(0, 300);
		chk(o_crc_err, 0);
		cyc_n(2 * INIT);
		chk(oe_rises, 0);
		i_bus_ok = 1'b1;
		wait_hi(1, 30000);
		chk(o_prog_status, 4'hB);
		chk(o_group_on, 2'h1);
		chk(o_aux_good, 4'hA);
		i_host_on = 2'h2;
		cyc_n(1);
		i_host_on = 2'h0;
		cyc_n(2);
		chk(o_group_on, 2'h3);
		cyc_n(8000);
		for (int n = 0; n < 4; n++)
			chk(o_mon[n], mon_exp[n]);
		host(1'b1, 2'h1, 4'h3, 8'h5A, 8'h00, 1'b0);
		host(1'b0, 2'h1, 4'h3, 8'h00, 8'h5A, 1'b0);
		host(1'b0, 2'h2, 4'h3, 8'h00, 8'h00, 1'b1);
		i_cfg.sw_wp = 1'b1;
		host(1'b1, 2'h1, 4'h3, 8'hC3, 8'h00, 1'b1);
		i_cfg.sw_wp = 1'b0;
		i_write_lock_n = 1'b0;
		cyc_n(6);
		host(1'b1, 2'h1, 4'h3, 8'hC3, 8'h00, 1'b1);
		i_write_lock_n = 1'b1;
		cyc_n(6);
		host(1'b0, 2'h1, 4'h3, 8'h00, 8'h5A, 1'b0);
		i_bus_ok = 1'b0;
		cyc_n(10);
		chk(o_prog_status, 4'h0);
		chk(o_group_on, 2'h0);
		chk(saves, 1);
		cyc_n(400);
		i_bus_ok = 1'b1;
		wait_hi(1, 30000);
		chk(o_prog_status, 4'hB);
		conclude();
	end
endmodule
